// ---- rtl/lcw_dev.sv ----
// Purpose: Device end: line-cycle apparent energy, waveform sample capture, pulse pins
// Assumes: Zero-crossing pulses, energy increments and live samples arrive synchronous to the clock
// Notes:   Burst read streams all sixteen sample words through a small FIFO
`include "lcw_defs.svh"
`default_nettype none

// Sample word FIFO; out side may stall so it really fills
module lcw_fifo
  import lcw_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
)(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] data_in,
  input  wire logic             valid_in,
  output logic                  ready_out,
  output logic [WIDTH-1:0]      data_out,
  output logic                  valid_out,
  input  wire logic             ready_in
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } lcw_fifo_s;
  lcw_fifo_s q, d;
  logic push, pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("lcw_fifo: DEPTH must be a power of two, at least 2");
  end

  assign ready_out = (q.cnt != (AW+1)'(DEPTH));
  assign valid_out = (q.cnt != '0);
  assign data_out  = q.mem[q.rp];
  assign push      = valid_in && ready_out;
  assign pop       = valid_out && ready_in;

  // Next state of pointers and storage
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = data_in;
      d.wp        = q.wp + 1'b1;
    end
    if (pop)
      d.rp = q.rp + 1'b1;
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      q <= '0;
    else
      q <= d;
  end
endmodule

// Functional notes
// RULE1 - Three-wire: line A-C rms into phase B
// RULE2 - Host clears phase B include in three-wire
// RULE3 - Line mode moves accumulators to energy registers
// RULE4 - Half-cycle count sets crossings per period
// RULE5 - Mode bit 2 selects line-cycle accumulation
// RULE6 - No clear-on-read while line mode active
// RULE7 - Count crossings only of selected phases
// RULE8 - Host enables one phase during calibration
// RULE9 - Latch all samples every 125 us
// RULE10 - Sample-ready flag at status bit 17
// RULE11 - Sample-ready interrupt gated by mask bit 17
// RULE12 - Samples read sign-extended to 32 bits
// RULE13 - Transfers sized 8, 16 or 32 bits
// RULE14 - Burst command returns all samples in order
// RULE15 - Three pulse pins, third shared with clock
// RULE16 - Capture port enabled suppresses third pulse
// RULE17 - Period end: flag, mask bit 5, restart
// RULE18 - Sample reads never alter sample registers
module lcw_dev
  import lcw_pkg::*;
#(
  parameter int SAMPLE_CYC = `LCW_SAMPLE_CYC,
  parameter int FIFO_DEPTH = 16
)(
  // Clock and reset
  input  wire logic             CORE_CLK_IN,
  input  wire logic             RST_N_IN,
  // Register link
  lcw_if.dev                    LINK,
  // Measurement inputs
  input  wire lcw_samples_t     SAMPLES_IN,
  input  wire logic [2:0]       ZERO_CROSS_IN,
  input  wire logic             ENERGY_STB_IN,
  input  wire logic [2:0][31:0] APPARENT_INC_IN,
  input  wire logic [31:0]      PHASE_B_RMS_IN,
  input  wire logic [31:0]      LINE_AC_RMS_IN,
  // Pulse converters and capture clock
  input  wire logic [2:0]       PULSE_IN,
  input  wire logic             CAPTURE_CLK_IN,
  // Outputs
  output logic [8:0]            PHASE_INCLUDE_OUT,
  output logic                  CAPT_ENABLE_OUT,
  output logic [31:0]           PHASE_B_RMS_OUT,
  output logic                  FIRST_PULSE_OUT,
  output logic                  SECOND_PULSE_OUT,
  output logic                  THIRD_PULSE_OUT
);
  lcw_dev_s    q, d;
  logic        f_ready;
  logic [31:0] f_data;
  logic        zx_hit;
  logic        period_end;
  logic [15:0] target;
  logic        wr_en, rd_en;

  if (SAMPLE_CYC < 1 || SAMPLE_CYC > 16384) begin : g_chk
    $error("lcw_dev: SAMPLE_CYC out of range");
  end

  // Sign extension of a sample word
  function automatic logic [31:0] sext(input logic [23:0] v);
    sext = {{8{v[23]}}, v}; // RULE12
  endfunction

  // Cut a word to the transfer size
  function automatic logic [31:0] sized(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      `LCW_SZ_8:  sized = {24'h0, v[7:0]}; // RULE13
      `LCW_SZ_16: sized = {16'h0, v[15:0]}; // RULE13
      default:    sized = v;
    endcase
  endfunction

  assign wr_en      = LINK.wr;
  assign rd_en      = LINK.rd;
  assign zx_hit     = |(ZERO_CROSS_IN & q.lcyc[`LCW_LC_ZX_HI:`LCW_LC_ZX_LO]); // RULE7
  // A zero count would close a period on every crossing; treat it as one crossing
  assign target     = (q.halfcyc == 16'h0) ? 16'h1 : q.halfcyc;
  assign period_end = q.lcyc[`LCW_LC_APPARENT] && zx_hit && (q.zx_cnt + 16'h1 >= target); // RULE4

  // Next state of the whole device end
  always_comb
  begin
    logic [31:0] inc;
    logic [31:0] rv;
    logic [7:0]  a;
    d        = q;
    inc      = '0;
    rv       = '0;
    a        = LINK.addr;
    d.rvalid = 1'b0;

    // Sample period timer and latch; reads never touch the copies
    if (q.tick == 14'(SAMPLE_CYC - 1))
    begin
      d.tick     = '0;
      d.samp     = SAMPLES_IN; // RULE9
      d.st_ready = 1'b1; // RULE10
    end
    else
      d.tick = q.tick + 14'h1;

    d.brms = (q.cfg[1:0] == `LCW_WIRE_3W) ? LINE_AC_RMS_IN : PHASE_B_RMS_IN; // RULE1

    // Register reads, answered one cycle later
    if (rd_en)
    begin
      if (a < 8'(`LCW_NUM_SAMPLES))
        rv = sext(q.samp[a[3:0]]); // RULE18
      else
        case (a)
          `LCW_OFS_STATUS:   rv = 32'(q.st_ready) << `LCW_ST_READY | 32'(q.st_done) << `LCW_ST_DONE;
          `LCW_OFS_MASK:     rv = 32'(q.msk_ready) << `LCW_ST_READY | 32'(q.msk_done) << `LCW_ST_DONE;
          `LCW_OFS_LINEMODE: rv = {24'h0, q.lcyc};
          `LCW_OFS_HALFCYC:  rv = {16'h0, q.halfcyc};
          `LCW_OFS_INCLUDE:  rv = {23'h0, q.incl_set};
          `LCW_OFS_CONFIG:   rv = {29'h0, q.cfg};
          `LCW_OFS_BRMS:     rv = q.brms;
          default:
            if (a >= `LCW_OFS_ACCUM_A && a <= `LCW_OFS_ACCUM_C)
              rv = q.vahr[2'(a - `LCW_OFS_ACCUM_A)];
            else
              rv = '0;
        endcase
      d.rdata  = sized(rv, LINK.size);
      d.rvalid = 1'b1;
    end

    // Register writes; status bits clear on a written one
    if (wr_en)
      case (a)
        `LCW_OFS_STATUS:
        begin
          if (LINK.wdata[`LCW_ST_READY])
            d.st_ready = 1'b0;
          if (LINK.wdata[`LCW_ST_DONE])
            d.st_done = 1'b0;
        end
        `LCW_OFS_MASK:
        begin
          d.msk_ready = LINK.wdata[`LCW_ST_READY];
          d.msk_done  = LINK.wdata[`LCW_ST_DONE];
        end
        `LCW_OFS_LINEMODE: d.lcyc     = LINK.wdata[7:0];
        `LCW_OFS_HALFCYC:  d.halfcyc  = LINK.wdata[15:0];
        `LCW_OFS_INCLUDE:  d.incl_set = LINK.wdata[8:0];
        `LCW_OFS_CONFIG:   d.cfg      = LINK.wdata[2:0];
        default:           d.cfg      = q.cfg;
      endcase
    // A fresh sample set in the clearing cycle keeps the flag
    if (q.tick == 14'(SAMPLE_CYC - 1))
      d.st_ready = 1'b1; // RULE10

    // Apparent energy accumulation per phase
    for (int p = 0; p < 3; p++)
    begin
      inc = ENERGY_STB_IN ? APPARENT_INC_IN[p] : 32'h0;
      if (q.lcyc[`LCW_LC_APPARENT]) // RULE5
      begin
        if (period_end)
        begin
          d.vahr[p] = q.acc[p] + inc; // RULE3
          d.acc[p]  = '0;
        end
        else
          d.acc[p] = q.acc[p] + inc;
      end
      else
      begin
        d.acc[p] = '0;
        if (rd_en && q.lcyc[`LCW_LC_CLR_RD] && a == `LCW_OFS_ACCUM_A + 8'(p))
          d.vahr[p] = inc; // RULE6
        else
          d.vahr[p] = q.vahr[p] + inc;
      end
    end

    // Half-cycle counting and period close
    if (!q.lcyc[`LCW_LC_APPARENT])
      d.zx_cnt = '0;
    else if (period_end)
    begin
      d.zx_cnt  = '0; // RULE17
      d.st_done = 1'b1; // RULE17
    end
    else if (zx_hit)
      d.zx_cnt = q.zx_cnt + 16'h1; // RULE4

    // Burst of all sample words into the FIFO
    if (LINK.burst && !q.bursting)
    begin
      d.bursting = 1'b1; // RULE14
      d.bidx     = '0;
    end
    else if (q.bursting && f_ready)
    begin
      d.bidx = q.bidx + 4'h1; // RULE14
      if (q.bidx == 4'hf)
        d.bursting = 1'b0;
    end

    // Pulse pins are active low; the third gives way to the capture clock
    d.pins[0] = PULSE_IN[0]; // RULE15
    d.pins[1] = PULSE_IN[1];
    d.pins[2] = q.cfg[`LCW_CFG_CAPT] ? CAPTURE_CLK_IN : PULSE_IN[2]; // RULE16
  end

  assign f_data = sext(q.samp[q.bidx]);

  lcw_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) i_lcw_fifo (
    .clk_in    (CORE_CLK_IN),
    .rst_n_in  (RST_N_IN),
    .data_in   (f_data),
    .valid_in  (q.bursting),
    .ready_out (f_ready),
    .data_out  (LINK.st_data),
    .valid_out (LINK.st_valid),
    .ready_in  (LINK.st_ready)
  );

  // State register with documented reset values
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      q          <= '0;
      q.lcyc     <= `LCW_RST_LINEMODE;
      q.halfcyc  <= `LCW_RST_HALFCYC;
      q.incl_set <= `LCW_RST_INCLUDE;
      q.pins     <= 3'h7;
    end
    else
      q <= d;
  end

  // Outputs
  assign LINK.rdata        = q.rdata;
  assign LINK.rvalid       = q.rvalid;
  assign LINK.irq          = (q.st_ready && q.msk_ready) || (q.st_done && q.msk_done); // RULE11 RULE17
  assign PHASE_INCLUDE_OUT = q.incl_set;
  assign CAPT_ENABLE_OUT   = q.cfg[`LCW_CFG_CAPT];
  assign PHASE_B_RMS_OUT   = q.brms;
  assign FIRST_PULSE_OUT   = q.pins[0];
  assign SECOND_PULSE_OUT  = q.pins[1];
  assign THIRD_PULSE_OUT   = q.pins[2];
endmodule
`default_nettype wire

// ---- rtl/lcw_defs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the line-cycle / waveform block
// Assumes: 125 MHz core clock, 32-bit register words
// Notes:   Device register offsets are word indices on the register link
`ifndef LCW_DEFS_SVH
`define LCW_DEFS_SVH

// Device register map
`define LCW_OFS_SAMPLE0      8'h00
`define LCW_NUM_SAMPLES      16
`define LCW_OFS_STATUS       8'h10
`define LCW_OFS_MASK         8'h11
`define LCW_OFS_LINEMODE     8'h12
`define LCW_OFS_HALFCYC      8'h13
`define LCW_OFS_INCLUDE      8'h14
`define LCW_OFS_CONFIG       8'h15
`define LCW_OFS_ACCUM_A      8'h16
`define LCW_OFS_ACCUM_C      8'h18
`define LCW_OFS_BRMS         8'h19

// Field positions
`define LCW_ST_DONE          5
`define LCW_ST_READY         17
`define LCW_LC_APPARENT      2
`define LCW_LC_ZX_LO         3
`define LCW_LC_ZX_HI         5
`define LCW_LC_CLR_RD        6
`define LCW_CFG_CAPT         2
`define LCW_WIRE_3W          2'h1
`define LCW_INCL_B0          1
`define LCW_INCL_B1          4
`define LCW_INCL_B2          7

// Reset values
`define LCW_RST_INCLUDE      9'h1ff
`define LCW_RST_HALFCYC      16'hffff
`define LCW_RST_LINEMODE     8'h78

// Waveform sample period
`define LCW_SAMPLE_NS        125000
`define LCW_CLK_NS           8
`define LCW_SAMPLE_CYC       (`LCW_SAMPLE_NS / `LCW_CLK_NS)

// Transfer sizes on the link
`define LCW_SZ_8             2'h0
`define LCW_SZ_16            2'h1
`define LCW_SZ_32            2'h2

// Host software register map
`define LCW_H_DEV_ADDR       8'h00
`define LCW_H_SIZE           8'h01
`define LCW_H_WRITE          8'h02
`define LCW_H_RDATA          8'h03
`define LCW_H_STATUS         8'h04
`define LCW_H_CMD            8'h05
`define LCW_H_MODE           8'h06

`endif

// ---- rtl/lcw_pkg.sv ----
// Purpose: Types shared by both ends of the line-cycle / waveform link
// Assumes: Constants come from lcw_defs.svh
// Notes:   State of each module is one packed struct
`default_nettype none
package lcw_pkg;
  typedef logic [15:0][23:0] lcw_samples_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_WAIT = 3'b010,
    H_DONE = 3'b100
  } lcw_host_e;

  typedef struct packed {
    lcw_samples_t     samp;
    logic [13:0]      tick;
    logic             st_ready;
    logic             st_done;
    logic             msk_ready;
    logic             msk_done;
    logic [7:0]       lcyc;
    logic [15:0]      halfcyc;
    logic [8:0]       incl_set;
    logic [2:0]       cfg;
    logic [2:0][31:0] acc;
    logic [2:0][31:0] vahr;
    logic [15:0]      zx_cnt;
    logic [31:0]      brms;
    logic [31:0]      rdata;
    logic             rvalid;
    logic             bursting;
    logic [3:0]       bidx;
    logic [2:0]       pins;
  } lcw_dev_s;

  typedef struct packed {
    lcw_host_e   fsm;
    logic [7:0]  dev_addr;
    logic [1:0]  size;
    logic [31:0] rdata;
    logic [31:0] sw_rdata;
    logic        three_wire;
    logic        calib;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        burst;
  } lcw_host_s;
endpackage
`default_nettype wire

// ---- rtl/lcw_if.sv ----
// Purpose: Register link between the metering device end and the host end
// Assumes: One clock shared by both ends
// Notes:   Burst words flow device to host with valid and ready
`default_nettype none
interface lcw_if;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [1:0]  size;
  logic        wr;
  logic        rd;
  logic        burst;
  logic [31:0] rdata;
  logic        rvalid;
  logic [31:0] st_data;
  logic        st_valid;
  logic        st_ready;
  logic        irq;

  modport dev (input addr, wdata, size, wr, rd, burst, st_ready,
               output rdata, rvalid, st_data, st_valid, irq);
  modport host (output addr, wdata, size, wr, rd, burst, st_ready,
                input rdata, rvalid, st_data, st_valid, irq);
endinterface
`default_nettype wire

// ---- rtl/lcw_host.sv ----
// Purpose: Host end: software port turned into single register transfers and bursts on the link
// Assumes: Device answers a read exactly one cycle after the strobe
// Notes:   Guards three-wire include bits and calibration phase choice on writes
`include "lcw_defs.svh"
`default_nettype none
module lcw_host
  import lcw_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  // Software port
  input  wire logic [7:0]  SW_ADDR_IN,
  input  wire logic [31:0] SW_WDATA_IN,
  input  wire logic        SW_WR_IN,
  input  wire logic        SW_RD_IN,
  output logic [31:0]      SW_RDATA_OUT,
  // Burst words and interrupt to the user
  output logic [31:0]      BURST_DATA_OUT,
  output logic             BURST_VALID_OUT,
  input  wire logic        BURST_READY_IN,
  output logic             IRQ_OUT,
  // Link
  lcw_if.host              LINK
);
  lcw_host_s   q, d;
  logic [31:0] wv;

  // Lowest set bit of the crossing select, used while calibrating
  function automatic logic [2:0] one_phase(input logic [2:0] v);
    one_phase = v & (~v + 3'h1);
  endfunction

  // Next state
  always_comb
  begin
    d       = q;
    d.wr    = 1'b0;
    d.rd    = 1'b0;
    d.burst = 1'b0;
    wv      = SW_WDATA_IN;

    // Filter outgoing writes against wiring and calibration settings
    if (q.dev_addr == `LCW_OFS_INCLUDE && q.three_wire)
    begin
      wv[`LCW_INCL_B0] = 1'b0; // RULE2
      wv[`LCW_INCL_B1] = 1'b0; // RULE2
      wv[`LCW_INCL_B2] = 1'b0; // RULE2
    end
    if (q.dev_addr == `LCW_OFS_LINEMODE)
    begin
      if (q.calib)
        wv[`LCW_LC_ZX_HI:`LCW_LC_ZX_LO] = one_phase(SW_WDATA_IN[`LCW_LC_ZX_HI:`LCW_LC_ZX_LO]); // RULE8
      if (SW_WDATA_IN[`LCW_LC_APPARENT])
        wv[`LCW_LC_CLR_RD] = 1'b0; // RULE6
    end

    if (SW_WR_IN)
      case (SW_ADDR_IN)
        `LCW_H_DEV_ADDR: d.dev_addr = SW_WDATA_IN[7:0];
        `LCW_H_SIZE:     d.size     = SW_WDATA_IN[1:0]; // RULE13
        `LCW_H_MODE:     d.calib    = SW_WDATA_IN[0];
        `LCW_H_WRITE:
        begin
          d.addr  = q.dev_addr;
          d.wdata = wv;
          d.wr    = (q.fsm == H_IDLE) || (q.fsm == H_DONE);
          if (q.dev_addr == `LCW_OFS_CONFIG)
            d.three_wire = (SW_WDATA_IN[1:0] == `LCW_WIRE_3W);
        end
        `LCW_H_CMD:
          if (q.fsm != H_WAIT)
          begin
            d.addr  = q.dev_addr;
            d.rd    = SW_WDATA_IN[0];
            d.burst = SW_WDATA_IN[1]; // RULE14
            if (SW_WDATA_IN[0])
              d.fsm = H_WAIT;
          end
        default:         d.calib = q.calib;
      endcase

    // Read waits for the answer strobe
    case (q.fsm)
      H_IDLE: d.fsm = d.fsm;
      H_WAIT:
        if (LINK.rvalid)
        begin
          d.rdata = LINK.rdata;
          d.fsm   = H_DONE;
        end
      H_DONE: d.fsm = d.fsm;
      default: d.fsm = H_IDLE;
    endcase

    // Software reads, answered one cycle later
    d.sw_rdata = '0;
    if (SW_RD_IN)
      case (SW_ADDR_IN)
        `LCW_H_DEV_ADDR: d.sw_rdata = {24'h0, q.dev_addr};
        `LCW_H_SIZE:     d.sw_rdata = {30'h0, q.size};
        `LCW_H_RDATA:    d.sw_rdata = q.rdata;
        `LCW_H_STATUS:   d.sw_rdata = {28'h0, q.three_wire, LINK.irq, q.fsm == H_DONE, q.fsm == H_WAIT};
        `LCW_H_MODE:     d.sw_rdata = {31'h0, q.calib};
        default:         d.sw_rdata = '0;
      endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      q      <= '0;
      q.fsm  <= H_IDLE;
      q.size <= `LCW_SZ_32;
    end
    else
      q <= d;
  end

  // Outputs
  assign SW_RDATA_OUT    = q.sw_rdata;
  assign LINK.addr       = q.addr;
  assign LINK.wdata      = q.wdata;
  assign LINK.size       = q.size;
  assign LINK.wr         = q.wr;
  assign LINK.rd         = q.rd;
  assign LINK.burst      = q.burst;
  assign LINK.st_ready   = BURST_READY_IN;
  assign BURST_DATA_OUT  = LINK.st_data;
  assign BURST_VALID_OUT = LINK.st_valid;
  assign IRQ_OUT         = LINK.irq;
endmodule
`default_nettype wire

// ---- sim/lcw_monitor.sv ----
// Purpose: Concurrent checks on the register link joining device and host ends
// Assumes: One clock; link signals taken straight from the interface
// Notes:   Wiring choice is tracked here from host writes to the config word
`default_nettype none
module lcw_monitor (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Link
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic [1:0]  size,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        burst,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  input  wire logic [31:0] st_data,
  input  wire logic        st_valid,
  input  wire logic        st_ready,
  input  wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic three_w_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Include filter only applies once three-wire has been written
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      three_w_q <= 1'b0;
    else if (wr && addr == 8'h15)
      three_w_q <= (wdata[1:0] == 2'h1);

  a_read_answer: assert property (rd |=> rvalid)
    else $error("read strobe got no answer");
  a_answer_cause: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  a_sample_sign: assert property (rvalid && $past(addr) < 8'h10 && $past(size) == 2'h2 |->
    rdata[31:24] == {8{rdata[23]}}) else $error("sample word not sign extended");
  a_cut_half: assert property (rvalid && $past(size) == 2'h1 |-> rdata[31:16] == 16'h0)
    else $error("half word read not cut");
  a_cut_byte: assert property (rvalid && $past(size) == 2'h0 |-> rdata[31:8] == 24'h0)
    else $error("byte read not cut");
  a_irq_status: assert property (rvalid && $past(addr) == 8'h10 && $past(size) == 2'h2
    && !rdata[17] && !rdata[5] |-> !$past(irq)) else $error("irq without status cause");
  a_burst_start: assert property (burst && !st_valid |-> ##2 st_valid)
    else $error("burst word late");
  a_stream_hold: assert property (st_valid && !st_ready |=> st_valid && $stable(st_data))
    else $error("stalled burst word changed");
  a_include_b: assert property (wr && addr == 8'h14 && three_w_q |->
    wdata[1] == 1'b0 && wdata[4] == 1'b0 && wdata[7] == 1'b0) else $error("phase b included");
  a_line_no_clr: assert property (wr && addr == 8'h12 && wdata[2] |-> !wdata[6])
    else $error("clear on read with line mode");
endmodule
`default_nettype wire

// ---- sim/test_line_cycle_energy_and_waveform_capture.sv ----
// Purpose: Self-checking bench joining device and host ends over the link
// Assumes: Sample period shortened to SAMP cycles to keep the run short
// Notes:   Device registers are reached only through the host software port
`default_nettype none
module test_line_cycle_energy_and_waveform_capture
  import lcw_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SAMP = 400;
  logic             clk, rst_n, sw_wr, sw_rd, bvalid, bready, irq, estb, cap_clk;
  logic             capt, p1, p2, p3;
  logic [7:0]       sw_addr;
  logic [31:0]      sw_wdata, sw_rdata, bdata, rms_b, rms_ac, bphase;
  logic [2:0]       zx, pulse;
  logic [8:0]       incl;
  logic [2:0][31:0] inc;
  lcw_samples_t     samp;
  int               n_fail, num_checks, cyc;

  lcw_if link ();
  lcw_dev #(.SAMPLE_CYC(SAMP), .FIFO_DEPTH(16)) i_lcw_dev (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .LINK(link), .SAMPLES_IN(samp), .ZERO_CROSS_IN(zx),
    .ENERGY_STB_IN(estb), .APPARENT_INC_IN(inc), .PHASE_B_RMS_IN(rms_b), .LINE_AC_RMS_IN(rms_ac),
    .PULSE_IN(pulse), .CAPTURE_CLK_IN(cap_clk), .PHASE_INCLUDE_OUT(incl), .CAPT_ENABLE_OUT(capt),
    .PHASE_B_RMS_OUT(bphase), .FIRST_PULSE_OUT(p1), .SECOND_PULSE_OUT(p2), .THIRD_PULSE_OUT(p3));
  lcw_host i_lcw_host (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .SW_ADDR_IN(sw_addr), .SW_WDATA_IN(sw_wdata),
    .SW_WR_IN(sw_wr), .SW_RD_IN(sw_rd), .SW_RDATA_OUT(sw_rdata), .BURST_DATA_OUT(bdata),
    .BURST_VALID_OUT(bvalid), .BURST_READY_IN(bready), .IRQ_OUT(irq), .LINK(link));
  lcw_monitor i_lcw_monitor (
    .clk(clk), .rst_n(rst_n), .addr(link.addr), .wdata(link.wdata), .size(link.size),
    .wr(link.wr), .rd(link.rd), .burst(link.burst), .rdata(link.rdata), .rvalid(link.rvalid),
    .st_data(link.st_data), .st_valid(link.st_valid), .st_ready(link.st_ready), .irq(link.irq));

  // 125 MHz clock and a cycle count for period checks
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;

  function automatic logic [31:0] sx(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // Software port cycles; strobes last one cycle
  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask
  task automatic dev_wr(input logic [7:0] a, input logic [31:0] d);
    sw_write(8'h00, {24'h0, a});
    sw_write(8'h02, d);
    repeat (3) @(posedge clk);
  endtask
  task automatic dev_rd(input logic [7:0] a, output logic [31:0] d);
    sw_write(8'h00, {24'h0, a});
    sw_write(8'h05, 32'h1);
    repeat (3) @(posedge clk);
    sw_read(8'h03, d);
  endtask
  task automatic set_samp(input logic [23:0] base);
    for (int i = 0; i < 16; i++)
      samp[i] <= base + 24'(i);
  endtask
  task automatic wait_irq(output int t);
    for (int k = 0; k < 3 * SAMP; k++)
    begin
      @(negedge clk);
      if (irq === 1'b1)
        break;
    end
    t = cyc;
    chk("irq rise", 32'h1, {31'h0, irq});
  endtask

  task automatic test_regs();
    logic [31:0] d;
    dev_rd(8'h12, d);
    chk("line mode reset", 32'h78, d);
    dev_rd(8'h13, d);
    chk("half count reset", 32'hffff, d);
    dev_rd(8'h30, d);
    chk("unmapped", 32'h0, d);
    $display("test_regs done");
  endtask

  task automatic test_wiring();
    logic [31:0] d;
    dev_wr(8'h15, 32'h1);
    dev_wr(8'h14, 32'h1ff);
    chk("include", 32'h16d, {23'h0, incl});
    dev_rd(8'h19, d);
    chk("b rms reg", rms_ac, d);
    chk("b rms pin", rms_ac, bphase);
    dev_wr(8'h15, 32'h0);
    dev_wr(8'h14, 32'h1ff);
    chk("include", 32'h1ff, {23'h0, incl});
    chk("b rms pin", rms_b, bphase);
    $display("test_wiring done");
  endtask

  task automatic test_pulses();
    @(posedge clk);
    pulse <= 3'b010;
    cap_clk <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("pulses", 32'h2, {29'h0, p3, p2, p1});
    dev_wr(8'h15, 32'h4);
    chk("capture on", 32'h1, {31'h0, capt});
    chk("pulses", 32'h6, {29'h0, p3, p2, p1});
    dev_wr(8'h15, 32'h0);
    $display("test_pulses done");
  endtask

  task automatic test_samples();
    logic [31:0] d;
    int t1;
    int t2;
    chk("irq masked", 32'h0, {31'h0, irq});
    dev_wr(8'h11, 32'h20000);
    dev_wr(8'h10, 32'h20000);
    wait_irq(t1);
    @(posedge clk);
    set_samp(24'h8abc00);
    dev_rd(8'h09, d);
    chk("old sample", sx(24'h123409), d);
    dev_wr(8'h10, 32'h20000);
    chk("ready cleared", 32'h0, {31'h0, irq});
    dev_rd(8'h10, d);
    chk("ready bit", 32'h0, {31'h0, d[17]});
    wait_irq(t2);
    chk("period", SAMP, t2 - t1);
    for (int k = 0; k < 2; k++)
    begin
      dev_rd(8'h09, d);
      chk("new sample", 32'hff8abc09, d);
    end
    sw_write(8'h01, 32'h1);
    dev_rd(8'h09, d);
    chk("half read", 32'hbc09, d);
    sw_write(8'h01, 32'h0);
    dev_rd(8'h09, d);
    chk("byte read", 32'h09, d);
    sw_write(8'h01, 32'h2);
    dev_wr(8'h11, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    dev_rd(8'h10, d);
    chk("ready flag", 32'h1, {31'h0, d[17]});
    $display("test_samples done");
  endtask

  task automatic test_burst();
    int n;
    @(posedge clk);
    bready <= 1'b0;
    sw_write(8'h05, 32'h2);
    repeat (40) @(posedge clk);
    chk("stalled head", sx(samp[0]), bdata);
    @(posedge clk);
    bready <= 1'b1;
    n = 0;
    for (int k = 0; k < 40 && n < 16; k++)
    begin
      @(negedge clk);
      if (bvalid === 1'b1)
      begin
        chk("burst word", sx(samp[n]), bdata);
        n++;
      end
    end
    chk("burst count", 32'd16, n);
    repeat (3) @(negedge clk);
    chk("drained", 32'h0, {31'h0, bvalid});
    $display("test_burst done");
  endtask

  task automatic test_line();
    logic [31:0] d;
    sw_write(8'h06, 32'h1);
    dev_wr(8'h12, 32'h3c);
    dev_rd(8'h12, d);
    chk("cal select", 32'h0c, d);
    sw_write(8'h06, 32'h0);
    dev_wr(8'h12, 32'h4c);
    dev_rd(8'h12, d);
    chk("line mode", 32'h0c, d);
    dev_wr(8'h13, 32'h3);
    dev_wr(8'h11, 32'h20);
    // Increments live only under the strobe so the period total is exact
    @(posedge clk);
    inc <= {32'd7, 32'd6, 32'd5};
    repeat (4)
    begin
      @(posedge clk) estb <= 1'b1;
      @(posedge clk) estb <= 1'b0;
    end
    inc <= '0;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk) zx <= (k < 4) ? 3'b010 : 3'b001;
      @(posedge clk) zx <= 3'b000;
    end
    dev_rd(8'h10, d);
    chk("done early", 32'h0, {31'h0, d[5]});
    @(posedge clk) zx <= 3'b001;
    @(posedge clk) zx <= 3'b000;
    repeat (2) @(posedge clk);
    #1;
    chk("done irq", 32'h1, {31'h0, irq});
    dev_rd(8'h16, d);
    chk("energy a", 32'd20, d);
    dev_rd(8'h18, d);
    chk("energy c", 32'd28, d);
    $display("test_line done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {rst_n, sw_wr, sw_rd, bready, estb, cap_clk, sw_addr, sw_wdata, zx, inc} = '0;
    {n_fail, num_checks} = '0;
    pulse = 3'b111;
    rms_b = 32'h0000_1111;
    rms_ac = 32'h0000_2222;
    set_samp(24'h123400);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    test_wiring();
    test_pulses();
    test_samples();
    test_burst();
    test_line();
    report_and_stop();
  end

  // Watchdog well beyond the thousand or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
